// ---- hdl/asrp_readout_port.sv ----
// asrp_readout_port: serial status/readout port of a multichannel converter.
// assumes pins arrive asynchronously; the analog core presents its result on resultIn.
`default_nettype none
// How it works
// RL1 - sdo moves after falling sck, sdi sampled on rising sck; host uses opposite edges
// RL2 - internal mode drives sck at conversion clock over 8; external mode reads it
// RL3 - at power-up and each cs fall, sck high picks internal, low external
// RL4 - host holds sck low at cs fall to get external clock mode
// RL5 - sdi ignored while cs high or converting; taken only in data output
// RL6 - channel bits shifted in during readout select the next conversion channel
// RL7 - sdo is high impedance whenever cs is high
// RL8 - with cs low in convert or sleep, sdo shows pending: high converting, low ready
// RL9 - after conversion, sleep until rising sck with cs low starts data output
// RL10 - data output sends the previous result on sdo, msb first
// RL11 - cs high at conversion end means the device sleeps on its own
// RL12 - the finished result is held in the shift register while sleeping
// RL13 - pending readable on first rising sck, last result bit on nineteenth
// RL14 - external mode: nineteenth falling sck starts conversion and drives sdo high
// RL15 - cs rising after data output began aborts and starts a new conversion
// RL16 - abort before the final channel bit keeps the old channel selection
// RL17 - host may abort between first rising and nineteenth falling sck edge
// RL18 - cs held low converts continuously at the full rate
// RL19 - host may watch pending fall as interrupt, or raise cs to release sdo
// RL20 - external 3-wire mode: sck alone controls conversion and output
// RL21 - internal 3-wire mode converts continuously, clocking out each result
// RL22 - word: bit 18 pending, bit 17 zero, bit 16 sign, bits 15..0 result
// RL23 - sck pulses beyond nineteen do not corrupt the serial data
// RL24 - external conversion clock used only at 2560 Hz or faster
// RL25 - convert, sleep and data output states with a nineteen edge counter
// RL26 - clock mode latched at cs fall and held until the next cs fall
module asrp_readout_port #(
  parameter int unsigned CONV_TICKS = asrp_pkg::CONV_TICKS,
  parameter int unsigned DETECT_CYCLES = asrp_pkg::DETECT_CYCLES,
  parameter int unsigned INT_OSC_DIV = asrp_pkg::INT_OSC_DIV,
  parameter int unsigned CHAN_BITS = asrp_pkg::CHAN_BITS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic csPinN,
  input wire logic sckPinIn,
  input wire logic sdiPin,
  input wire logic rejectionClockPin,
  input wire asrp_pkg::asrp_result_t resultIn,
  output var asrp_pkg::asrp_pins_t pinsOut,
  output logic convStart,
  output logic [CHAN_BITS-1:0] channelSel,
  output logic extSckMode,
  output logic extConvClk
);
  localparam int unsigned CW = $clog2(CONV_TICKS + 1);

  if (CHAN_BITS < 2 || CHAN_BITS > 18 || CONV_TICKS < 2) begin : g_bad_params
    $error("asrp_readout_port: unsupported parameter values");
  end

  typedef struct packed {
    asrp_pkg::asrp_state_t st;
    logic extSck;
    logic [2:0] init;
    logic csPrev;
    logic sckPrev;
    logic [CW-1:0] convCnt;
    logic [1:0] divCnt;
    logic [4:0] bitCnt;
    logic [asrp_pkg::WORD_BITS-1:0] shift;
    logic [CHAN_BITS-1:0] chanShift;
    logic [CHAN_BITS-1:0] channel;
    asrp_pkg::asrp_pins_t pins;
    logic convStart;
  } asrp_port_t;

  asrp_port_t q, n;
  asrp_pkg::asrp_pinin_t pin;
  logic convTick;
  logic cs, sck, csRise, csFall, extRise, extFall, intRise, intFall, rise, fall;

  asrp_sync #(
    .W($bits(asrp_pkg::asrp_pinin_t)),
    .RST(asrp_pkg::PIN_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din({csPinN, sckPinIn, sdiPin, rejectionClockPin}),
    .dout(pin)
  );

  asrp_conv_clk #(
    .DETECT_CYCLES(DETECT_CYCLES),
    .INT_OSC_DIV(INT_OSC_DIV)
  ) u_cclk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .refClk(pin.rejClk),
    .convTick(convTick),
    .extClk(extConvClk)
  );

  assign cs = pin.csN;
  assign sck = pin.sck;
  assign csRise = cs & ~q.csPrev;
  assign csFall = ~cs & q.csPrev;
  assign extRise = q.extSck & sck & ~q.sckPrev;
  assign extFall = q.extSck & ~sck & q.sckPrev;
  // internal sck toggles every half period of conversion clock ticks
  assign intRise = ~q.extSck && q.st == asrp_pkg::ST_DATA && convTick
                   && q.divCnt == 2'(asrp_pkg::SCK_HALF - 1) && !q.pins.sckOut;
  assign intFall = ~q.extSck && q.st == asrp_pkg::ST_DATA && convTick
                   && q.divCnt == 2'(asrp_pkg::SCK_HALF - 1) && q.pins.sckOut;
  assign rise = extRise | intRise; // RL1
  assign fall = extFall | intFall; // RL1

  always_comb begin
    logic [4:0] cnt;
    logic start;
    cnt = q.bitCnt;
    start = 1'h0;
    n = q;
    n.convStart = 1'h0;
    n.csPrev = cs;
    n.sckPrev = sck;
    // clock source chosen after power-up settling and at every cs fall
    if (q.init != asrp_pkg::INIT_LAST) begin
      n.init = q.init + 3'h1;
      if (q.init == asrp_pkg::INIT_LAST - 3'h1) begin
        n.extSck = ~sck; // RL3
      end
    end else if (csFall) begin
      n.extSck = ~sck; // RL3 RL26
    end
    if (q.st == asrp_pkg::ST_DATA && !q.extSck && convTick) begin
      n.divCnt = q.divCnt + 2'h1; // RL2
      if (q.divCnt == 2'(asrp_pkg::SCK_HALF - 1)) begin
        n.pins.sckOut = ~q.pins.sckOut; // RL2
      end
    end
    unique case (q.st)
      asrp_pkg::ST_CONV: begin
        if (convTick) begin
          n.convCnt = q.convCnt + CW'(1);
          if (q.convCnt == CW'(CONV_TICKS - 1)) begin
            n.convCnt = '0;
            n.st = asrp_pkg::ST_SLEEP; // RL11
            n.shift = {1'h0, 1'h0, resultIn.sign, resultIn.value}; // RL22
          end
        end
      end
      asrp_pkg::ST_SLEEP: begin // RL12
        if (!cs && q.extSck && extRise) begin
          n.st = asrp_pkg::ST_DATA; // RL9 RL20
        end else if (!cs && !q.extSck) begin
          n.st = asrp_pkg::ST_DATA; // RL18 RL21
          n.divCnt = '0;
          n.pins.sckOut = 1'h0;
        end
      end
      asrp_pkg::ST_DATA: begin
        if (csRise) begin
          start = 1'h1; // RL15
        end else if (fall) begin
          n.shift = {q.shift[asrp_pkg::WORD_BITS-2:0], 1'h0}; // RL10
          // internal mode ends half a period after the 19th rise, so bit 0 stands across it
          if (q.bitCnt == asrp_pkg::LAST_BIT) begin
            start = 1'h1; // RL14 RL21 RL25
          end
        end
      end
      default: begin
        n.st = asrp_pkg::ST_CONV;
      end
    endcase
    // sdi taken on rising edges only inside a readout, while cs is low
    if (!cs && rise && (q.st == asrp_pkg::ST_DATA || q.st == asrp_pkg::ST_SLEEP)) begin // RL23
      cnt = q.bitCnt + 5'h1;
      n.bitCnt = cnt; // RL25
      if (q.bitCnt < 5'(CHAN_BITS)) begin
        n.chanShift = {q.chanShift[CHAN_BITS-2:0], pin.sdi}; // RL5 RL6
      end
    end
    if (start) begin
      n.st = asrp_pkg::ST_CONV;
      n.convCnt = '0;
      n.convStart = 1'h1;
      n.bitCnt = '0;
      n.pins.sckOut = 1'h1;
      if (cnt >= 5'(CHAN_BITS)) begin
        n.channel = n.chanShift; // RL6 RL16
      end
    end
    n.pins.sdoOeN = cs; // RL7
    n.pins.sckOeN = n.extSck | cs; // RL2
    // pending flag outside data output, result msb first inside it
    n.pins.sdoOut = (n.st == asrp_pkg::ST_DATA) ? n.shift[asrp_pkg::PEND_POS]
                                               : (n.st == asrp_pkg::ST_CONV); // RL8 RL13
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= asrp_pkg::ST_CONV;
      q.csPrev <= 1'h1;
      q.sckPrev <= 1'h1;
      q.pins <= 4'hF;
    end else begin
      q <= n;
    end
  end

  assign pinsOut = q.pins;
  assign convStart = q.convStart;
  assign channelSel = q.channel;
  assign extSckMode = q.extSck;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_readout_begin;
    q.st == asrp_pkg::ST_SLEEP ##1 q.st == asrp_pkg::ST_DATA;
  endsequence
  sequence s_abort;
    q.st == asrp_pkg::ST_DATA && csRise;
  endsequence

  property p_sdo_hiz;
    cs |=> pinsOut.sdoOeN;
  endproperty
  a_sdo_hiz: assert property (p_sdo_hiz) else $error("sdo driven with cs high"); // RL7

  property p_pending;
    q.st != asrp_pkg::ST_DATA |-> pinsOut.sdoOut == (q.st == asrp_pkg::ST_CONV);
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag wrong on sdo"); // RL8

  property p_sleep_hold;
    q.st == asrp_pkg::ST_SLEEP && q.extSck && !(rise && !cs)
      |=> q.st == asrp_pkg::ST_SLEEP && $stable(q.shift);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left or result lost"); // RL9

  property p_first_bit;
    s_readout_begin |-> !pinsOut.sdoOut;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("pending not low at readout"); // RL13

  property p_abort;
    s_abort |=> q.st == asrp_pkg::ST_CONV && convStart && q.bitCnt == 5'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not restart conversion"); // RL15

  property p_chan_keep;
    s_abort and (q.bitCnt < 5'(CHAN_BITS)) |=> $stable(channelSel);
  endproperty
  a_chan_keep: assert property (p_chan_keep) else $error("partial channel was stored"); // RL16

  property p_ext_end;
    q.st == asrp_pkg::ST_DATA && extFall && !csRise && q.bitCnt == asrp_pkg::LAST_BIT
      |=> q.st == asrp_pkg::ST_CONV ##0 pinsOut.sdoOut ##1 q.st == asrp_pkg::ST_CONV;
  endproperty
  a_ext_end: assert property (p_ext_end) else $error("19th fall did not convert"); // RL14

  property p_sdi_ignore;
    q.st == asrp_pkg::ST_CONV || cs |=> $stable(q.chanShift);
  endproperty
  a_sdi_ignore: assert property (p_sdi_ignore) else $error("sdi taken while ignored"); // RL5

  property p_mode_hold;
    q.init == asrp_pkg::INIT_LAST && !csFall |=> $stable(extSckMode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("clock mode changed"); // RL26

  property p_mode_pick;
    q.init == asrp_pkg::INIT_LAST && csFall |=> extSckMode == !$past(sck);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("clock mode wrongly picked"); // RL3

  property p_shift_msb;
    q.st == asrp_pkg::ST_DATA && fall && !csRise && q.bitCnt < asrp_pkg::LAST_BIT
      |=> q.shift == {$past(q.shift[asrp_pkg::WORD_BITS-2:0]), 1'h0};
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("result not shifted msb first"); // RL10

  property p_word;
    q.st == asrp_pkg::ST_CONV ##1 q.st == asrp_pkg::ST_SLEEP
      |-> q.shift[asrp_pkg::PEND_POS] == 1'h0 && q.shift[asrp_pkg::ZERO_POS] == 1'h0;
  endproperty
  a_word: assert property (p_word) else $error("result word layout wrong"); // RL22

  sequence s_int_last_rise;
    q.st == asrp_pkg::ST_DATA && intRise && !cs && q.bitCnt == asrp_pkg::LAST_BIT - 5'h1;
  endsequence
  sequence s_int_last_fall;
    q.st == asrp_pkg::ST_DATA && intFall && !cs && q.bitCnt == asrp_pkg::LAST_BIT;
  endsequence

  property p_int_last_bit;
    s_int_last_rise |=> q.st == asrp_pkg::ST_DATA && pinsOut.sckOut && $stable(pinsOut.sdoOut);
  endproperty
  a_int_last_bit: assert property (p_int_last_bit) else $error("last bit not held"); // RL13

  property p_int_end;
    s_int_last_fall |=> q.st == asrp_pkg::ST_CONV && pinsOut.sckOut && pinsOut.sdoOut
      && convStart;
  endproperty
  a_int_end: assert property (p_int_end) else $error("internal readout did not end"); // RL21
endmodule // asrp_readout_port
`default_nettype wire

// ---- hdl/asrp_pkg.sv ----
// asrp_pkg: constants and types shared by the serial readout port files.
// assumes a single 40 MHz system clock; no software-visible registers.
`default_nettype none
package asrp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // least external conversion clock frequency that counts as present
  localparam int unsigned DETECT_HZ = 2560;
  localparam int unsigned DETECT_CYCLES = CLK_HZ / DETECT_HZ;
  // conversion length in conversion clock periods
  localparam int unsigned CONV_TICKS = 20510;
  localparam int unsigned INT_OSC_DIV = 287;
  localparam int unsigned SCK_DIV = 8;
  localparam int unsigned SCK_HALF = SCK_DIV / 2;
  localparam int unsigned CHAN_BITS = 5;
  localparam int unsigned WORD_BITS = 19;
  localparam int unsigned PEND_POS = 18;
  localparam int unsigned ZERO_POS = 17;
  localparam int unsigned SIGN_POS = 16;
  localparam int unsigned RES_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h13;
  localparam logic [2:0] INIT_LAST = 3'h5;

  typedef enum logic [2:0] {
    ST_CONV  = 3'h1,
    ST_SLEEP = 3'h2,
    ST_DATA  = 3'h4
  } asrp_state_t;

  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic sdoOut;
    logic sdoOeN;
  } asrp_pins_t;

  typedef struct packed {
    logic csN;
    logic sck;
    logic sdi;
    logic rejClk;
  } asrp_pinin_t;

  localparam asrp_pinin_t PIN_RST = 4'hE;

  typedef struct packed {
    logic sign;
    logic [RES_BITS-1:0] value;
  } asrp_result_t;
endpackage
`default_nettype wire

// ---- hdl/asrp_sync.sv ----
// asrp_sync: three-stage pin synchroniser; output moves when stages two and three agree.
// assumes inputs are asynchronous to clk_sys.
`default_nettype none
module asrp_sync #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } asrp_sync_t;

  asrp_sync_t q, n;

  always_comb begin
    n = q;
    n.s1 = din;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= {RST, RST, RST, RST};
    end else begin
      q <= n;
    end
  end

  assign dout = q.o;
endmodule // asrp_sync
`default_nettype wire

// ---- hdl/asrp_conv_clk.sv ----
// asrp_conv_clk: conversion clock tick, from the external pin when fast enough, else internal.
// assumes refClk is already synchronised to clk_sys.
`default_nettype none
module asrp_conv_clk #(
  parameter int unsigned DETECT_CYCLES = asrp_pkg::DETECT_CYCLES,
  parameter int unsigned INT_OSC_DIV = asrp_pkg::INT_OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic refClk,
  output logic convTick,
  output logic extClk
);
  localparam int unsigned GW = $clog2(DETECT_CYCLES + 1);
  localparam int unsigned DW = $clog2(INT_OSC_DIV + 1);

  if (DETECT_CYCLES < 2 || INT_OSC_DIV < 1) begin : g_bad_counts
    $error("asrp_conv_clk: counts too small");
  end

  typedef struct packed {
    logic prev;
    logic ext;
    logic tick;
    logic [GW-1:0] gap;
    logic [DW-1:0] div;
  } asrp_cclk_t;

  asrp_cclk_t q, n;
  logic rise;

  assign rise = refClk & ~q.prev;

  always_comb begin
    n = q;
    n.prev = refClk;
    // edges closer than the detect period mean an external clock is present
    if (rise) begin
      n.gap = '0;
      if (q.gap < GW'(DETECT_CYCLES)) begin
        n.ext = 1'h1; // RL24
      end
    end else if (q.gap == GW'(DETECT_CYCLES)) begin
      n.ext = 1'h0; // RL24
    end else begin
      n.gap = q.gap + GW'(1);
    end
    n.div = (q.div == DW'(INT_OSC_DIV - 1)) ? '0 : q.div + DW'(1);
    n.tick = q.ext ? rise : (q.div == DW'(INT_OSC_DIV - 1));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign convTick = q.tick;
  assign extClk = q.ext;
endmodule // asrp_conv_clk
`default_nettype wire

// ---- testbench/asrp_host_model.sv ----
// asrp_host_model: behavioural serial master facing the readout port pins.
// assumes pins are looked at on clk_sys; sck has a pull-up when nobody drives it.
`default_nettype none
module asrp_host_model (
  input wire logic clk_sys,
  input wire asrp_pkg::asrp_pins_t pins,
  output var logic csPinN,
  output wire logic sckPinIn,
  output var logic sdiPin,
  output var logic wordValid,
  output var logic [18:0] wordSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CB = asrp_pkg::CHAN_BITS;
  logic hostDrv = 1'h0;
  logic hostSck = 1'h0;
  logic loadReq = 1'h0;
  logic sckPrev = 1'h1;
  logic [CB-1:0] chanNext = '0;
  logic [CB-1:0] shReg = '0;
  int rises = 0;
  wire logic sdoWire;
  assign sdoWire = pins.sdoOeN ? 1'bz : pins.sdoOut;
  assign sckPinIn = !pins.sckOeN ? pins.sckOut : (hostDrv ? hostSck : 1'h1);
  initial begin
    csPinN = 1'h1;
    sdiPin = 1'h1;
    wordValid = 1'h0;
    wordSeen = '0;
  end
  // sdo taken on rising sck, sdi moved on falling sck
  always @(posedge clk_sys) begin
    sckPrev <= sckPinIn;
    wordValid <= 1'h0;
    if (loadReq) begin
      shReg <= chanNext;
      sdiPin <= chanNext[CB-1];
      rises <= 0;
    end else if (!csPinN && sckPinIn && !sckPrev) begin
      wordSeen <= {wordSeen[17:0], sdoWire};
      rises <= rises + 1;
      if (rises == 18) wordValid <= 1'h1;
    end else if (!csPinN && !sckPinIn && sckPrev && rises > 0) begin
      shReg <= shReg << 1;
      sdiPin <= shReg[CB-2];
    end
  end
  task automatic load(input logic ext, input logic [CB-1:0] chan);
    @(posedge clk_sys);
    hostDrv <= ext;
    hostSck <= 1'h0;
    chanNext <= chan;
    loadReq <= 1'h1;
    @(posedge clk_sys);
    loadReq <= 1'h0;
  endtask
  task automatic select();
    repeat (8) @(posedge clk_sys);
    csPinN <= 1'h0;
  endtask
  task automatic deselect();
    @(posedge clk_sys);
    csPinN <= 1'h1;
  endtask
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_sys);
      hostSck <= 1'h1;
      repeat (8) @(posedge clk_sys);
      hostSck <= 1'h0;
    end
  endtask
endmodule // asrp_host_model
`default_nettype wire

// ---- testbench/asrp_readout_port_tb.sv ----
// asrp_readout_port_tb: self-checking bench for the serial readout port.
// assumes asrp_host_model on the pins and shortened conversion and detect counts.
`default_nettype none
module asrp_readout_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rstn;
  logic csPinN;
  wire logic sckPinIn;
  logic sdiPin;
  logic rejectionClockPin;
  asrp_pkg::asrp_result_t resultIn;
  asrp_pkg::asrp_pins_t pinsOut;
  logic convStart;
  logic [4:0] channelSel;
  logic extSckMode;
  logic extConvClk;
  logic wordValid;
  logic [18:0] wordSeen;
  logic [18:0] expQ[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int nStarts = 0;
  always #12.5 clk_sys = ~clk_sys;
  asrp_readout_port #(.CONV_TICKS(8), .DETECT_CYCLES(64), .INT_OSC_DIV(2), .CHAN_BITS(5))
      asrp_readout_port_i (.clk_sys(clk_sys), .rstn(rstn), .csPinN(csPinN),
      .sckPinIn(sckPinIn), .sdiPin(sdiPin), .rejectionClockPin(rejectionClockPin),
      .resultIn(resultIn), .pinsOut(pinsOut), .convStart(convStart),
      .channelSel(channelSel), .extSckMode(extSckMode), .extConvClk(extConvClk));
  asrp_host_model host_i (.clk_sys(clk_sys), .pins(pinsOut), .csPinN(csPinN),
      .sckPinIn(sckPinIn), .sdiPin(sdiPin), .wordValid(wordValid), .wordSeen(wordSeen));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_sdo(input logic v);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk_sys);
      if (pinsOut.sdoOeN === 1'h0 && pinsOut.sdoOut === v) break;
    end
    check(32'(i < 2000), 32'h1);
  endtask
  // expected word from the result the core holds now, then a fresh one
  task automatic note_word();
    expQ.push_back({2'h0, resultIn.sign, resultIn.value});
    resultIn <= 17'($urandom);
  endtask
  always @(posedge clk_sys) if (convStart === 1'h1) nStarts <= nStarts + 1;
  always @(posedge clk_sys) begin
    if (wordValid === 1'h1)
      check(32'(wordSeen), expQ.size() > 0 ? 32'(expQ.pop_front()) : 32'hFFFF_FFFF);
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    int k;
    int st;
    logic [4:0] ch;
    logic [4:0] nx;
    k = $urandom(94);
    rstn = 1'h0;
    rejectionClockPin = 1'h0;
    resultIn = 17'($urandom);
    repeat (10) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (40) @(posedge clk_sys);
    check(32'(pinsOut.sdoOeN), 32'h1);
    ch = 5'h15;
    host_i.load(1'h1, ch);
    host_i.select();
    repeat (10) @(posedge clk_sys);
    check(32'(extSckMode), 32'h1);
    for (k = 0; k < 3; k++) begin
      wait_sdo(1'h0);
      note_word();
      if (k > 0) begin
        ch = 5'($urandom);
        host_i.load(1'h1, ch);
      end
      st = nStarts;
      host_i.pulses(19);
      repeat (8) @(posedge clk_sys);
      check(32'({pinsOut.sdoOeN, pinsOut.sdoOut}), 32'h1);
      check(nStarts, st + 1);
      check(32'(channelSel), 32'(ch));
    end
    for (k = 3; k <= 5; k += 2) begin
      if (k == 5) host_i.select();
      wait_sdo(1'h0);
      nx = ch ^ 5'($urandom_range(31, 1));
      host_i.load(1'h1, nx);
      st = nStarts;
      host_i.pulses(k);
      host_i.deselect();
      repeat (8) @(posedge clk_sys);
      check(nStarts, st + 1);
      check(32'(pinsOut.sdoOeN), 32'h1);
      if (k == 5) ch = nx;
      check(32'(channelSel), 32'(ch));
    end
    repeat (60) @(posedge clk_sys);
    note_word();
    ch = 5'($urandom);
    host_i.load(1'h0, ch);
    st = nStarts;
    host_i.select();
    for (k = 0; k < 2000 && expQ.size() > 0; k++) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    check(32'(extSckMode), 32'h0);
    check(32'(expQ.size()), 32'h0);
    check(nStarts, st + 1);
    check(32'({pinsOut.sdoOut, sckPinIn}), 32'h3);
    check(32'(channelSel), 32'(ch));
    host_i.deselect();
    for (k = 20; k <= 50; k += 30) begin
      repeat (12) begin
        repeat (k) @(posedge clk_sys);
        rejectionClockPin <= 1'h1;
        repeat (k) @(posedge clk_sys);
        rejectionClockPin <= 1'h0;
      end
      check(32'(extConvClk), 32'(k < 32));
    end
    wrap_up();
  end
endmodule // asrp_readout_port_tb
`default_nettype wire
